// ---- pkg/dild_consts.svh ----
// constants of the converter input latch and segment decoder
// assumes it is included by bare name wherever a figure is needed
`ifndef DILD_CONSTS_SVH
`define DILD_CONSTS_SVH

// sample word layout, straight binary
`define DILD_WORD_W 8
`define DILD_MSB_POS 7
`define DILD_LSB_POS 0

// segmentation: upper bits thermometer, lower bits binary
`define DILD_UNARY_BITS 4
`define DILD_BIN_BITS 4
`define DILD_UNARY_SEGS 15
`define DILD_UNARY_WEIGHT 16

// transfer figures: code divides by 256, complement is 255 minus code
`define DILD_FS_DIV 256
`define DILD_FS_CODE 8'hff

// synchroniser depth for pin controls
`define DILD_SYNC_STAGES 2

// reset value and buffer depth
`define DILD_RST_CODE 8'h00
`define DILD_BUF_DEPTH 2

`endif

// ---- pkg/dild_pkg.sv ----
// types shared by the latch, decoder and buffer of the converter front end
// assumes dild_consts.svh is on the include path
`include "dild_consts.svh"

package dild_pkg;

  // sample word as it arrives on the parallel pins
  typedef struct packed {
    logic sample_msb;
    logic [`DILD_WORD_W-3:0] mid_bits;
    logic sample_lsb;
  } dild_word_t;

  // one setting of all differential current switches, 1 steers to the true node
  typedef struct packed {
    logic [`DILD_UNARY_SEGS-1:0] unary;
    logic [`DILD_BIN_BITS-1:0] binary;
  } dild_steer_t;

endpackage : dild_pkg

// ---- verilog/dild_buf2.sv ----
// two-entry buffer with valid and ready on both sides
// assumes a single clock; clk_en low freezes every flop
`timescale 1ns/1ps
`include "dild_consts.svh"

module dild_buf2
  import dild_pkg::*;
#(
  parameter int W = `DILD_WORD_W,
  parameter int DEPTH = `DILD_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic empty
);

  // pointer logic below only serves a depth of two
  if (DEPTH != 2 || W < 1) begin : gen_bad_depth
    $error("dild_buf2 serves depth 2 and a positive width only");
  end

  logic [W-1:0] mem_ff [0:1]; // the edge-triggered storage itself
  logic wr_ptr_ff; // next slot to fill
  logic rd_ptr_ff; // slot at the head
  logic [1:0] count_ff; // 0..2 words held
  logic push;
  logic pop;

  assign in_ready = (count_ff != 2'd2);
  assign out_valid = (count_ff != 2'd0);
  assign empty = (count_ff == 2'd0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = clk_en && in_valid && in_ready;
  assign pop = clk_en && out_valid && out_ready;

  // capture on the rising edge only; no reset on data, so no constant is needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      // simultaneous push and pop leave the level alone
      if (push && !pop) begin
        count_ff <= count_ff + 2'd1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 2'd1;
      end
    end
  end

endmodule : dild_buf2

// ---- verilog/dild_seg_decode.sv ----
// combinational segment decoder: code to switch settings
// assumes the code comes from the latch, never from the pins
`timescale 1ns/1ps
`include "dild_consts.svh"

module dild_seg_decode
  import dild_pkg::*;
(
  input wire logic [`DILD_WORD_W-1:0] code,
  output dild_steer_t steer
);

  logic [`DILD_UNARY_BITS-1:0] upper; // thermometer part of the code

  assign upper = code[`DILD_WORD_W-1:`DILD_BIN_BITS];

  // a thermometer upper part keeps glitch energy low on major carries
  always_comb begin
    steer.binary = code[`DILD_BIN_BITS-1:0];
    for (int i = 0; i < `DILD_UNARY_SEGS; i++) begin
      steer.unary[i] = (i < int'(upper));
    end
  end

endmodule : dild_seg_decode

// ---- verilog/dild_top.sv ----
// converter front end: input latch, buffer, segment decoder, switch register
// assumes sample_in and sample_valid come from logic on clk; the standby
// and reference pins are asynchronous and are synchronised here
`timescale 1ns/1ps
`include "dild_consts.svh"

// Contract
// - eight-bit word, first pin is msb
// - standby while power-down input is high
// - undriven power-down input means normal operation
// - reference select: 0 internal, 1 external
// - decoder fed from latched word only
// - every segment steered to one node
// - true current is code over 256
// - complement is 255 minus code
// - unsigned binary, captured on rising edge
module dild_top
  import dild_pkg::*;
#(
  parameter int WORD_W = `DILD_WORD_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [WORD_W-1:0] sample_in,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic standby_request,
  input wire logic standby_driven,
  input wire logic ref_select_ext,
  output dild_steer_t steer_out,
  output dild_steer_t steer_comp,
  output logic steer_valid,
  input wire logic steer_ready,
  output logic [WORD_W-1:0] current_out_true,
  output logic [WORD_W-1:0] current_out_complement,
  output logic standby_active,
  output logic ref_internal_en,
  output logic ref_external_en
);

  // the decoder split and the 255 figure are fixed to eight bits
  // a generate-time error stops elaboration before any cycle runs
  if (WORD_W != `DILD_WORD_W) begin : gen_bad_width
    $error("dild_top serves an eight-bit word only");
  end

  // ------------------------------------------------------------------
  // pin controls: two flops before any logic looks at them
  // ------------------------------------------------------------------
  logic stby_pin; // pin level as the pad resolves it
  logic stby_meta_ff; // first stage, read by the second only
  logic stby_sync_ff; // second stage, safe to use
  logic ref_meta_ff; // first stage of reference select
  logic ref_sync_ff; // second stage of reference select

  // an undriven pad falls to the pull-down level, i.e. low
  assign stby_pin = standby_driven && standby_request;

  // standby synchroniser
  // the pin may move at any time and the first flop may go metastable,
  // so only the second flop is read by logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stby_meta_ff <= 1'b0;
      stby_sync_ff <= 1'b0;
    end else if (clk_en) begin
      stby_meta_ff <= stby_pin;
      stby_sync_ff <= stby_meta_ff;
    end
  end

  // reference select synchroniser; resets to internal reference
  // the reference changes slowly, so three edges of delay cost nothing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_meta_ff <= 1'b0;
      ref_sync_ff <= 1'b0;
    end else if (clk_en) begin
      ref_meta_ff <= ref_select_ext;
      ref_sync_ff <= ref_meta_ff;
    end
  end

  // ------------------------------------------------------------------
  // mode outputs, registered
  // ------------------------------------------------------------------
  logic standby_ff; // converter in low-power standby
  logic ref_ext_ff; // external reference chosen

  // standby follows the synchronised pin level, high means standby
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      standby_ff <= 1'b0;
    end else if (clk_en) begin
      standby_ff <= stby_sync_ff;
    end
  end

  // reference source: 0 selects internal, 1 external
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_ext_ff <= 1'b0;
    end else if (clk_en) begin
      ref_ext_ff <= ref_sync_ff;
    end
  end

  assign standby_active = standby_ff;
  assign ref_external_en = ref_ext_ff;
  assign ref_internal_en = ~ref_ext_ff;

  // ------------------------------------------------------------------
  // input latch: the buffer entries are the edge-triggered latches
  // ------------------------------------------------------------------
  dild_word_t word_in; // pin word, msb on the first pin
  logic [WORD_W-1:0] head_code; // latched word at the buffer head
  logic head_valid; // a latched word waits
  logic head_take; // switch register accepts the head
  logic buf_empty; // buffer holds nothing

  assign word_in = dild_word_t'(sample_in);

  dild_buf2 #(
    .W(WORD_W),
    .DEPTH(`DILD_BUF_DEPTH)
  ) u_latch (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .in_data(word_in),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(head_code),
    .out_valid(head_valid),
    .out_ready(head_take),
    .empty(buf_empty)
  );

  // ------------------------------------------------------------------
  // decoder on the latched word
  // ------------------------------------------------------------------
  dild_steer_t nxt_steer; // decoded switch setting for the head word

  dild_seg_decode u_dec (
    .code(head_code),
    .steer(nxt_steer)
  );

  // ------------------------------------------------------------------
  // switch register with update handshake
  // ------------------------------------------------------------------
  dild_steer_t steer_ff; // settings now applied to the switches
  logic [WORD_W-1:0] true_units_ff; // true current in full-scale/256 units
  logic [WORD_W-1:0] comp_units_ff; // complement current in the same units
  logic upd_valid_ff; // a fresh setting awaits the analog side
  logic slot_free; // switch register may take a new word

  // standby stalls updates; words stay latched so none is lost
  assign slot_free = !upd_valid_ff || steer_ready;
  assign head_take = head_valid && slot_free && !standby_ff;

  // load one clock after the capturing edge, hold until the next update
  // trade-off: one cycle of latency buys a decoder that never sees the pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      steer_ff <= '0;
      true_units_ff <= `DILD_RST_CODE;
      comp_units_ff <= `DILD_FS_CODE;
    end else if (clk_en && head_take) begin
      steer_ff <= nxt_steer;
      true_units_ff <= head_code;
      comp_units_ff <= `DILD_FS_CODE - head_code;
    end
  end

  // update flag: set by a load, cleared once the analog side takes it
  // set wins, so a back-to-back stream keeps the flag high without a gap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upd_valid_ff <= 1'b0;
    end else if (clk_en) begin
      if (head_take) begin
        upd_valid_ff <= 1'b1; // a new load wins over acceptance
      end else if (steer_ready) begin
        upd_valid_ff <= 1'b0;
      end
    end
  end

  assign steer_out = steer_ff;
  assign steer_comp = ~steer_ff;
  assign steer_valid = upd_valid_ff;
  assign current_out_true = true_units_ff;
  assign current_out_complement = comp_units_ff;

  // ------------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------------
  // helpers below only feed assertions and drive no output
  // current weight of a switch setting in full-scale/256 units
  function automatic logic [8:0] steer_weight(input dild_steer_t s);
    logic [8:0] acc;
    acc = 9'(s.binary);
    for (int i = 0; i < `DILD_UNARY_SEGS; i++) begin
      if (s.unary[i]) begin
        acc = acc + 9'(`DILD_UNARY_WEIGHT);
      end
    end
    return acc;
  endfunction : steer_weight

  logic [8:0] units_sum; // true plus complement units
  assign units_sum = 9'(true_units_ff) + 9'(comp_units_ff);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  // pin properties: four steady samples cover the three-edge sync delay
  standby_enter_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (stby_pin && clk_en)[*4] |=> standby_active
  ) else $error("standby not entered after high power-down input");

  standby_leave_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (!stby_pin && clk_en)[*4] |=> !standby_active
  ) else $error("standby held after low power-down input");

  pulldown_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (!standby_driven && clk_en)[*4] |=> !standby_active
  ) else $error("floating power-down input caused standby");

  ref_select_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (clk_en && ref_select_ext)[*4] |=> (ref_external_en && !ref_internal_en)
  ) else $error("external reference not selected");

  ref_internal_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (clk_en && !ref_select_ext)[*4] |=> (ref_internal_en && !ref_external_en)
  ) else $error("internal reference not selected");

  // datapath properties: capture, load, hold and refusal
  latch_delay_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (clk_en && sample_valid && sample_ready && buf_empty)
      ##1 (clk_en && slot_free && !standby_ff)
      |=> (steer_valid && current_out_true == $past(sample_in, 2))
  ) else $error("latched word not applied one clock after capture");

  load_applied_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (clk_en && head_take) |=> (steer_valid && current_out_true == $past(head_code))
  ) else $error("accepted word not applied at the next edge");

  valid_clear_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (clk_en && steer_valid && steer_ready && !head_take) |=> !steer_valid
  ) else $error("update flag held after acceptance");

  full_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (clk_en && !sample_ready && !head_take) |=> !sample_ready
  ) else $error("full latch pair offered room with nothing leaving");

  buffer_fill_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (clk_en && sample_valid && sample_ready && !head_take && !buf_empty) |=> !sample_ready
  ) else $error("second latched word did not fill the pair");

  // current properties: decoded weights must match the unit codes
  steer_split_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (steer_comp == ~steer_out) && (steer_weight(steer_comp) == 9'(`DILD_FS_CODE) - steer_weight(steer_out))
  ) else $error("segment not steered to exactly one node");

  true_weight_a: assert property (
    @(posedge clk) disable iff (!resetn)
    steer_weight(steer_out) == 9'(current_out_true)
  ) else $error("switch weight differs from true current code");

  full_sum_a: assert property (
    @(posedge clk) disable iff (!resetn)
    units_sum == 9'(`DILD_FS_CODE)
  ) else $error("true and complement do not sum to full scale");

  hold_stall_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (steer_valid && !steer_ready) |=> (steer_valid && $stable(steer_out))
  ) else $error("switch setting changed while update stalled");

  standby_stall_a: assert property (
    @(posedge clk) disable iff (!resetn)
    standby_ff |=> $stable(steer_out)
  ) else $error("switch setting updated during standby");

  // clock enable: a low enable must leave every register where it was
  freeze_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !clk_en |=> ($stable(steer_out) && $stable(steer_valid) && $stable(standby_active))
  ) else $error("state moved while clock enable low");

endmodule : dild_top

// ---- tb/dild_source.sv ----
// sample source model standing where synthesizer logic feeds the converter
// assumes one clock; words change only at the falling edge and wait for ready
`timescale 1ns/1ps

module dild_source (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic sample_ready,
  output logic [7:0] sample_in,
  output logic sample_valid
);
  logic [7:0] pending [$]; // words still to offer, oldest first
  logic took; // head word was accepted at the last rising edge

  initial begin
    sample_in = 8'h00;
    sample_valid = 1'b0;
    took = 1'b0;
  end

  // queue a word, bit 7 is the first pin, unsigned binary
  task automatic put(input logic [7:0] word);
    pending.push_back(word);
  endtask : put

  // acceptance is judged from the values held before the rising edge
  always @(posedge clk) begin
    took <= sample_valid && sample_ready && clk_en;
  end

  // offer the head word and hold it until taken
  always @(negedge clk) begin
    if (took) begin
      void'(pending.pop_front());
    end
    if (pending.size() != 0) begin
      sample_in = pending[0];
      sample_valid = 1'b1;
    end else begin
      // released data keeps moving so a stale word is never mistaken for a live one
      sample_in = ~sample_in;
      sample_valid = 1'b0;
    end
  end
endmodule : dild_source

// ---- tb/dild_top_test.sv ----
// self-checking bench for the converter input latch and segment decoder
// assumes dild_source feeds the sample port; one 125 MHz clock, inputs moved at falling edges
`timescale 1ns/1ps
`include "dild_consts.svh"

module dild_top_test
  import dild_pkg::*;
;
  logic clk, resetn, clk_en, sample_valid, sample_ready, steer_valid, steer_ready;
  logic standby_request, standby_driven, ref_select_ext, standby_active, ref_internal_en, ref_external_en;
  logic [7:0] sample_in, current_out_true, current_out_complement;
  dild_steer_t steer_out, steer_comp;
  int num_errors, compares;
  logic [7:0] codes [6] = '{8'h00, 8'h80, 8'hff, 8'h5a, 8'h01, 8'h10}; // ends and segment edges
  logic [7:0] stall_w [4] = '{8'h3c, 8'hc3, 8'h7e, 8'h81}; // one more than the path can hold

  // clock at 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  dild_top u_dild_top (.clk(clk), .resetn(resetn), .clk_en(clk_en), .sample_in(sample_in),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .standby_request(standby_request),
    .standby_driven(standby_driven), .ref_select_ext(ref_select_ext), .steer_out(steer_out),
    .steer_comp(steer_comp), .steer_valid(steer_valid), .steer_ready(steer_ready),
    .current_out_true(current_out_true), .current_out_complement(current_out_complement),
    .standby_active(standby_active), .ref_internal_en(ref_internal_en), .ref_external_en(ref_external_en));

  dild_source u_dild_source (.clk(clk), .clk_en(clk_en), .sample_ready(sample_ready),
    .sample_in(sample_in), .sample_valid(sample_valid));

  // expected switch pattern: thermometer on the upper nibble, binary below
  function automatic dild_steer_t exp_steer(input logic [7:0] c);
    dild_steer_t s;
    for (int i = 0; i < `DILD_UNARY_SEGS; i++) s.unary[i] = (i < c[7:4]);
    s.binary = c[3:0];
    return s;
  endfunction : exp_steer

  task automatic chk_word(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_steer(input dild_steer_t got, input dild_steer_t exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_steer

  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // one applied code seen on every output that depends on it
  task automatic check_apply(input logic [7:0] c);
    chk_steer(steer_out, exp_steer(c), "switch setting");
    chk_steer(steer_comp, dild_steer_t'(~exp_steer(c)), "complement switches");
    chk_word(current_out_true, c, "true current");
    chk_word(current_out_complement, 8'hff - c, "complement current");
    chk_bit(steer_valid, 1'b1, "update flag");
  endtask : check_apply

  // values right at release of reset
  task automatic test_reset;
    chk_steer(steer_out, exp_steer(8'h00), "reset switches");
    chk_word(current_out_complement, 8'hff, "reset complement");
    chk_word(current_out_true, 8'h00, "reset true");
    chk_bit(steer_valid, 1'b0, "reset flag");
    chk_bit(ref_external_en, 1'b0, "reset external");
    chk_bit(standby_active, 1'b0, "reset standby");
    chk_bit(ref_internal_en, 1'b1, "reset reference");
    chk_bit(sample_ready, 1'b1, "reset room");
  endtask : test_reset

  // back-to-back words, one update per cycle, two cycles after the offer
  task automatic test_stream;
    steer_ready = 1'b1;
    @(posedge clk);
    foreach (codes[i]) u_dild_source.put(codes[i]);
    repeat (3) @(negedge clk);
    foreach (codes[i]) begin
      check_apply(codes[i]);
      @(negedge clk);
    end
    chk_bit(steer_valid, 1'b0, "flag after accept");
  endtask : test_stream

  // analog side stalls: the path fills, refuses, then drains in order
  task automatic test_stall;
    steer_ready = 1'b0;
    @(posedge clk);
    foreach (stall_w[i]) u_dild_source.put(stall_w[i]);
    repeat (8) @(negedge clk);
    check_apply(stall_w[0]);
    chk_bit(sample_ready, 1'b0, "full refuses");
    steer_ready = 1'b1;
    for (int i = 1; i < 4; i++) begin
      @(negedge clk);
      check_apply(stall_w[i]);
    end
    @(negedge clk);
    chk_bit(steer_valid, 1'b0, "drained");
  endtask : test_stall

  // open pin stays running; driven high freezes updates after three edges
  task automatic test_standby;
    standby_driven = 1'b0;
    standby_request = 1'b1;
    repeat (4) @(negedge clk);
    chk_bit(standby_active, 1'b0, "open pin");
    standby_driven = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(standby_active, 1'b0, "standby early");
    @(negedge clk);
    chk_bit(standby_active, 1'b1, "standby entered");
    @(posedge clk);
    u_dild_source.put(8'h99);
    repeat (5) @(negedge clk);
    chk_word(current_out_true, 8'h81, "frozen in standby");
    chk_bit(steer_valid, 1'b0, "no update in standby");
    standby_request = 1'b0;
    repeat (5) @(negedge clk);
    chk_word(current_out_true, 8'h99, "applied after standby");
  endtask : test_standby

  // reference select follows the pin three edges later, both ways
  task automatic test_reference;
    ref_select_ext = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(ref_external_en, 1'b0, "external early");
    @(negedge clk);
    chk_bit(ref_external_en, 1'b1, "external selected");
    chk_bit(ref_internal_en, 1'b0, "internal off");
    ref_select_ext = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit(ref_internal_en, 1'b1, "internal back");
  endtask : test_reference

  // clock enable low freezes capture, update and acceptance
  task automatic test_freeze;
    steer_ready = 1'b0;
    clk_en = 1'b0;
    @(posedge clk);
    u_dild_source.put(8'h42);
    repeat (4) @(negedge clk);
    chk_word(current_out_true, 8'h99, "frozen word");
    chk_bit(steer_valid, 1'b0, "frozen no update");
    chk_bit(sample_ready, 1'b1, "frozen room");
    clk_en = 1'b1;
    repeat (2) @(negedge clk);
    check_apply(8'h42);
    clk_en = 1'b0;
    steer_ready = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(steer_valid, 1'b1, "frozen flag");
    clk_en = 1'b1;
    @(negedge clk);
    chk_bit(steer_valid, 1'b0, "flag after freeze");
  endtask : test_freeze

  task automatic test_done;
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // main sequence; the clock-enable freeze runs last
  initial begin
    num_errors = 0;
    compares = 0;
    clk_en = 1'b1;
    resetn = 1'b0;
    steer_ready = 1'b0;
    standby_request = 1'b0;
    standby_driven = 1'b1;
    ref_select_ext = 1'b0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    test_reset;
    test_stream;
    test_stall;
    test_standby;
    test_reference;
    test_freeze;
    test_done;
  end

  // the whole run needs well under a hundred cycles
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    test_done;
  end
endmodule : dild_top_test
